// ===== core/asu_pkg.sv
/*
 Package for the asynchronous serial channel: register offsets, field positions,
 reset values, modes and timing constants. Assumes a 32-bit classic Wishbone bus.
*/
package asu_pkg;
    localparam logic [5:0] ADDR_TX_BUFFER = 6'h00;
    localparam logic [5:0] ADDR_RX_BUFFER = 6'h04;
    localparam logic [5:0] ADDR_BAUD_DIVIDER = 6'h08;
    localparam logic [5:0] ADDR_SERIAL_MODE = 6'h0C;
    localparam logic [5:0] ADDR_SERIAL_CONTROL_0 = 6'h10;
    localparam logic [5:0] ADDR_SERIAL_CONTROL_1 = 6'h14;
    localparam logic [5:0] ADDR_SPECIAL_MODE_1 = 6'h18;
    localparam logic [5:0] ADDR_SPECIAL_MODE_2 = 6'h1C;
    localparam logic [5:0] ADDR_SPECIAL_MODE_3 = 6'h20;
    localparam logic [5:0] ADDR_SPECIAL_MODE_4 = 6'h24;
    localparam logic [5:0] ADDR_SHARED_CONTROL = 6'h28;

    localparam logic [2:0] LEN_7 = 3'h4;
    localparam logic [2:0] LEN_8 = 3'h5;
    localparam logic [2:0] LEN_9 = 3'h6;

    // Serial mode fields
    localparam int MODE_CLKDIR = 3;
    localparam int MODE_STOP = 4;
    localparam int MODE_PODD = 5;
    localparam int MODE_PON = 6;
    localparam int MODE_POL = 7;
    // Control 0 fields
    localparam int C0_HSDIR = 2;
    localparam int C0_SHEMPTY = 3;
    localparam int C0_HSDIS = 4;
    localparam int C0_OD = 5;
    localparam int C0_ORDER = 7;
    // Control 1 fields
    localparam int C1_TE = 0;
    localparam int C1_TBE = 1;
    localparam int C1_RE = 2;
    localparam int C1_RC = 3;
    localparam int C1_IRQSRC = 4;
    localparam int C1_LOGINV = 6;
    // Shared control fields
    localparam int SH_IRQSRC = 0;
    localparam int SH_REROUTE = 6;
    // Rx buffer error flags
    localparam int RB_OVR = 12;
    localparam int RB_FRM = 13;
    localparam int RB_PAR = 14;
    localparam int RB_SUM = 15;

    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_C0 = 8'h10;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [3:0] OVERSAMPLE = 4'hF;
    localparam logic [3:0] MID_SAMPLE = 4'h7;

    typedef enum logic [2:0] {ASU_IDLE, ASU_START, ASU_DATA, ASU_PAR, ASU_STOP} asu_state_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } asu_wb_req_s;
endpackage

// ===== core/asu_uart.sv
/*
 Asynchronous serial channel core with classic Wishbone register slave.
 Assumes pins pass through two flip-flops here; the pad logic resolves
 the open-drain serial output and the two-way handshake pin from the enables.
*/
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asu_uart
    import asu_pkg::*;
#(
    parameter int CHANNEL = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] wb_dat_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic transfer_clock_pin,
    input wire logic handshake_pin_i,
    output logic handshake_pin_o,
    output logic handshake_pin_oe,
    input wire logic peer_handshake_pin,
    output logic tx_irq,
    output logic rx_irq
);
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Pin synchronisers; stage one is read by stage two only
    logic [3:0] pin_s1, pin_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
        end else begin
            pin_s1 <= {serial_in_pin, transfer_clock_pin, handshake_pin_i, peer_handshake_pin};
            pin_s2 <= pin_s1;
        end
    end

    asu_wb_req_s req;
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

    logic [7:0] serial_mode, serial_control_0, baud_divider, shared_serial_control;
    logic [7:0] special_mode_1, special_mode_2, special_mode_3, special_mode_4;
    logic tx_enable_bit, rx_enable_bit, ch2_tx_irq_source, data_logic_invert;
    logic [8:0] tx_buffer, rx_data;
    logic tx_buffer_empty_flag, shifter_empty_flag, rx_complete_flag;
    logic ovr, frm, par;
    logic wr, rd_rx, load_tx, rx_done, tx_done, rx_ovr_now, rx_frm_now, rx_par_now;
    logic [8:0] rx_word;

    assign wr = req.cyc && req.stb && req.we && !wb_ack_o && req.sel[0];
    assign rd_rx = req.cyc && req.stb && !req.we && !wb_ack_o && req.adr == ADDR_RX_BUFFER;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wb_ack_o <= 1'b0;
        else wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
    end

    // Config writes: the whole channel ignores field bits that the mode leaves unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_mode <= RST_MODE;
            serial_control_0 <= RST_C0;
            baud_divider <= RST_BAUD;
            shared_serial_control <= 8'h00;
            special_mode_1 <= 8'h00;
            special_mode_2 <= 8'h00;
            special_mode_3 <= 8'h00;
            special_mode_4 <= 8'h00;
            tx_enable_bit <= 1'b0;
            rx_enable_bit <= 1'b0;
            ch2_tx_irq_source <= 1'b0;
            data_logic_invert <= 1'b0;
        end else if (wr) begin
            unique case (req.adr)
                ADDR_SERIAL_MODE: serial_mode <= req.dat[7:0];
                ADDR_SERIAL_CONTROL_0: serial_control_0 <= req.dat[7:0];
                ADDR_BAUD_DIVIDER: baud_divider <= req.dat[7:0];
                ADDR_SHARED_CONTROL: shared_serial_control <= req.dat[7:0];
                ADDR_SPECIAL_MODE_1: special_mode_1 <= req.dat[7:0];
                ADDR_SPECIAL_MODE_2: special_mode_2 <= req.dat[7:0];
                ADDR_SPECIAL_MODE_3: special_mode_3 <= req.dat[7:0];
                ADDR_SPECIAL_MODE_4: special_mode_4 <= req.dat[7:0];
                ADDR_SERIAL_CONTROL_1: begin
                    tx_enable_bit <= req.dat[C1_TE];
                    rx_enable_bit <= req.dat[C1_RE];
                    ch2_tx_irq_source <= req.dat[C1_IRQSRC];
                    data_logic_invert <= req.dat[C1_LOGINV];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        wb_dat_o = 32'h0;
        unique case (req.adr)
            ADDR_RX_BUFFER: wb_dat_o = {16'h0, par | frm | ovr, par, frm, ovr, 3'h0, rx_data};
            ADDR_SERIAL_MODE: wb_dat_o = {24'h0, serial_mode};
            ADDR_SERIAL_CONTROL_0: wb_dat_o = {24'h0, serial_control_0[7:4], shifter_empty_flag,
                                               serial_control_0[2:0]};
            ADDR_SERIAL_CONTROL_1: wb_dat_o = {24'h0, 1'b0, data_logic_invert, 1'b0, ch2_tx_irq_source,
                                               rx_complete_flag, rx_enable_bit, tx_buffer_empty_flag,
                                               tx_enable_bit};
            ADDR_SPECIAL_MODE_1: wb_dat_o = {24'h0, special_mode_1};
            ADDR_SPECIAL_MODE_2: wb_dat_o = {24'h0, special_mode_2};
            ADDR_SPECIAL_MODE_3: wb_dat_o = {24'h0, special_mode_3};
            ADDR_SPECIAL_MODE_4: wb_dat_o = {24'h0, special_mode_4};
            ADDR_SHARED_CONTROL: wb_dat_o = {24'h0, shared_serial_control};
            default: wb_dat_o = 32'h0;
        endcase
    end

    // Mode decode; special-mode registers are stored but do not steer this mode
    logic async_on, is7, is8, is9, lsb_order, pol_inv, log_inv, cts_used, rts_used;
    logic [3:0] nbits;
    assign is7 = serial_mode[2:0] == LEN_7;
    assign is8 = serial_mode[2:0] == LEN_8;
    assign is9 = serial_mode[2:0] == LEN_9;
    assign async_on = is7 | is8 | is9;
    assign nbits = is7 ? 4'h7 : (is8 ? 4'h8 : 4'h9);
    assign lsb_order = !(is8 && serial_control_0[C0_ORDER]);
    assign pol_inv = (CHANNEL == 2) && serial_mode[MODE_POL];
    assign log_inv = (CHANNEL == 2) && data_logic_invert;
    assign cts_used = !serial_control_0[C0_HSDIS] && !serial_control_0[C0_HSDIR];
    assign rts_used = !serial_control_0[C0_HSDIS] && serial_control_0[C0_HSDIR];

    // Count source: f1, f8, f32 or f2 (setting 3) prescale, or external pin edges
    logic [4:0] pre;
    logic ext_d, src_tick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= 5'h0;
            ext_d <= 1'b0;
        end else begin
            pre <= pre + 5'h1;
            ext_d <= pin_s2[2];
        end
    end
    always_comb begin
        if (serial_mode[MODE_CLKDIR]) src_tick = pin_s2[2] && !ext_d;
        else begin
            unique case (serial_control_0[1:0])
                2'h0: src_tick = 1'b1;
                2'h1: src_tick = pre[2:0] == 3'h7;
                2'h2: src_tick = pre == 5'h1F;
                default: src_tick = pre[0];
            endcase
        end
    end

    // Baud counter gives one tick per (n+1) source ticks; 16 ticks make a bit
    logic [7:0] brg;
    logic tick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) brg <= 8'h0;
        else if (src_tick) brg <= (brg == 8'h0) ? baud_divider : brg - 8'h1;
    end
    assign tick = src_tick && brg == 8'h0;

    // Transmit buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer <= 9'h0;
            tx_buffer_empty_flag <= 1'b1;
        end else if (wr && req.adr == ADDR_TX_BUFFER) begin
            tx_buffer <= {req.sel[1] & req.dat[8], req.dat[7:0]};
            tx_buffer_empty_flag <= 1'b0;
        end else if (load_tx) tx_buffer_empty_flag <= 1'b1;
    end

    // Transmitter
    asu_state_e tx_state;
    logic [8:0] tx_sh;
    logic [3:0] tx_os, tx_cnt;
    logic tx_par, tx_line, cts_ok;
    logic [7:0] tx_rev, rx_rev;
    assign cts_ok = !cts_used || !(((CHANNEL == 0) && shared_serial_control[SH_REROUTE]) ? pin_s2[0] : pin_s2[1]);
    // Mode gating keeps a buffered character from being dropped while the channel is off
    assign load_tx = async_on && tx_state == ASU_IDLE && tx_enable_bit && !tx_buffer_empty_flag && cts_ok;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= ASU_IDLE;
            tx_sh <= 9'h0;
            tx_os <= 4'h0;
            tx_cnt <= 4'h0;
            tx_par <= 1'b0;
            tx_line <= 1'b1;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (!async_on) begin
                tx_state <= ASU_IDLE;
                tx_line <= 1'b1;
            end else if (load_tx) begin
                tx_state <= ASU_START;
                tx_sh <= lsb_order ? tx_buffer : {1'b0, tx_rev};
                tx_par <= serial_mode[MODE_PODD];
                tx_os <= 4'h0;
                tx_cnt <= 4'h0;
                tx_line <= 1'b0;
            end else if (tick && tx_state != ASU_IDLE) begin
                tx_os <= tx_os + 4'h1;
                if (tx_os == OVERSAMPLE) begin
                    unique case (tx_state)
                        ASU_START, ASU_DATA: begin
                            if (tx_state == ASU_DATA && tx_cnt == nbits) begin
                                tx_state <= serial_mode[MODE_PON] ? ASU_PAR : ASU_STOP;
                                tx_line <= serial_mode[MODE_PON] ? tx_par : 1'b1;
                                tx_cnt <= 4'h0;
                            end else begin
                                tx_state <= ASU_DATA;
                                tx_line <= tx_sh[0] ^ log_inv;
                                tx_par <= tx_par ^ tx_sh[0] ^ log_inv;
                                tx_sh <= {1'b0, tx_sh[8:1]};
                                tx_cnt <= tx_cnt + 4'h1;
                            end
                        end
                        ASU_PAR: begin
                            tx_state <= ASU_STOP;
                            tx_line <= 1'b1;
                        end
                        ASU_STOP: begin
                            if (tx_cnt == {3'h0, serial_mode[MODE_STOP]}) begin
                                tx_state <= ASU_IDLE;
                                tx_done <= 1'b1;
                            end
                            tx_cnt <= tx_cnt + 4'h1;
                        end
                        default: tx_state <= ASU_IDLE;
                    endcase
                end
            end
        end
    end
    assign shifter_empty_flag = tx_state == ASU_IDLE;

    // Receiver; the start bit is taken on any tick that sees the line low, with no prior idle line needed
    asu_state_e rx_state;
    logic rx_line;
    logic [3:0] rx_os, rx_cnt;
    logic [8:0] rx_sh;
    logic rx_par;
    // Byte mirror for MSB-first transfer
    for (genvar g = 0; g < 8; g++) begin : g_mirror
        assign tx_rev[g] = tx_buffer[7 - g];
        assign rx_rev[g] = rx_sh[8 - g];
    end
    assign rx_line = pin_s2[3] ^ pol_inv;
    assign rx_word = lsb_order ? (is7 ? {2'h0, rx_sh[8:2]} : (is8 ? {1'b0, rx_sh[8:1]} : rx_sh))
                               : {1'b0, rx_rev};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= ASU_IDLE;
            rx_os <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sh <= 9'h0;
            rx_par <= 1'b0;
            rx_done <= 1'b0;
            rx_par_now <= 1'b0;
            rx_frm_now <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_enable_bit || !async_on) rx_state <= ASU_IDLE;
            else if (rx_state == ASU_IDLE) begin
                if (tick && !rx_line) begin
                    rx_state <= ASU_START;
                    rx_os <= 4'h0;
                end
            end else if (tick) begin
                rx_os <= rx_os + 4'h1;
                if (rx_os == MID_SAMPLE && rx_state == ASU_START) begin
                    // Phase restarts at the start bit centre only, so later bits are sampled mid-bit
                    rx_os <= 4'h0;
                    rx_state <= rx_line ? ASU_IDLE : ASU_DATA; // Glitch rejects
                    rx_cnt <= 4'h0;
                    rx_par <= serial_mode[MODE_PODD];
                end
                if (rx_os == OVERSAMPLE && rx_state != ASU_START) begin
                    unique case (rx_state)
                        ASU_DATA: begin
                            rx_sh <= {rx_line ^ log_inv, rx_sh[8:1]};
                            rx_par <= rx_par ^ rx_line;
                            rx_cnt <= rx_cnt + 4'h1;
                            if (rx_cnt == nbits - 4'h1) rx_state <= serial_mode[MODE_PON] ? ASU_PAR : ASU_STOP;
                        end
                        ASU_PAR: begin
                            rx_par_now <= rx_par ^ rx_line;
                            rx_state <= ASU_STOP;
                        end
                        ASU_STOP: begin
                            rx_frm_now <= !rx_line;
                            rx_state <= ASU_IDLE;
                            rx_done <= 1'b1;
                        end
                        default: rx_state <= ASU_IDLE;
                    endcase
                end
            end
            if (rx_state == ASU_START && rx_os == MID_SAMPLE) rx_par_now <= 1'b0;
        end
    end

    // Receive buffer; a new character wins over a simultaneous read clear
    assign rx_ovr_now = rx_complete_flag && !rd_rx;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= 9'h0;
            rx_complete_flag <= 1'b0;
            ovr <= 1'b0;
            frm <= 1'b0;
            par <= 1'b0;
        end else if (!rx_enable_bit) begin
            rx_complete_flag <= 1'b0;
            ovr <= 1'b0;
            frm <= 1'b0;
            par <= 1'b0;
        end else if (rx_done) begin
            rx_data <= rx_word;
            rx_complete_flag <= 1'b1;
            ovr <= rx_ovr_now;
            frm <= rx_frm_now;
            par <= rx_par_now;
        end else if (rd_rx) rx_complete_flag <= 1'b0;
    end

    // Transmit interrupt source select
    logic irq_src;
    assign irq_src = (CHANNEL == 2) ? ch2_tx_irq_source : shared_serial_control[SH_IRQSRC + (CHANNEL == 1 ? 1 : 0)];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            tx_irq <= irq_src ? tx_done : load_tx;
            rx_irq <= rx_done && rx_enable_bit;
        end
    end

    // Pin drive: receive-only or idle leaves the line at mark
    logic out_level;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_pin <= 1'b1;
            serial_out_oe <= 1'b0;
            handshake_pin_o <= 1'b1;
            handshake_pin_oe <= 1'b0;
        end else begin
            serial_out_pin <= out_level;
            serial_out_oe <= async_on && !(serial_control_0[C0_OD] && out_level);
            handshake_pin_o <= rx_complete_flag || !rx_enable_bit;
            handshake_pin_oe <= async_on && rts_used;
        end
    end
    assign out_level = (tx_enable_bit ? tx_line : 1'b1) ^ pol_inv;

    AST_TBE_SET: assert property (@(posedge clk) disable iff (!rst_n)
        load_tx && !(wr && req.adr == ADDR_TX_BUFFER) |=> tx_buffer_empty_flag)
        else $error("buffer empty not set after load");
    AST_NO_TX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_enable_bit && shifter_empty_flag |=> shifter_empty_flag) else $error("frame began while transmit disabled");
    AST_SHIFT_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
        load_tx |=> !shifter_empty_flag) else $error("shifter empty during frame");
    AST_RC_SET: assert property (@(posedge clk) disable iff (!rst_n)
        rx_done && rx_enable_bit |=> rx_complete_flag) else $error("complete flag missed");
    AST_RX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !rx_enable_bit |=> rx_state == ASU_IDLE) else $error("receiver ran while disabled");
    AST_START_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        load_tx |=> !tx_line) else $error("start bit not low");
    AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_enable_bit && async_on && !pol_inv |=> serial_out_pin) else $error("line not high");
    AST_CTS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        cts_used && CHANNEL != 0 && pin_s2[1] |-> !load_tx) else $error("sent without clear");
    COV_TX: cover property (@(posedge clk) disable iff (!rst_n) tx_done);
    COV_RX: cover property (@(posedge clk) disable iff (!rst_n) rx_done);
    COV_OVR: cover property (@(posedge clk) disable iff (!rst_n) rx_done && rx_ovr_now);
endmodule
`default_nettype wire

// ===== tb/asu_remote.sv
/*
 Remote serial partner: sends 8N1 frames LSB first and receives frames seen on the device's output line.
 Assumes a bit time of BIT device clocks and an idle-high, pulled-up line.
*/
`timescale 1ns/1ps
`default_nettype none
module asu_remote #(
    parameter int BIT = 16
) (
    input wire logic clk,
    input wire logic line,
    output logic tx_line,
    output logic [7:0] got,
    output int got_cnt
);
    initial begin
        tx_line = 1'b1;
        got = 8'h00;
        got_cnt = 0;
    end
    // Start low, data, stop high
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        tx_line <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            tx_line <= b[i];
        end
        repeat (BIT) @(posedge clk);
        tx_line <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // Samples at mid-bit, so a wrong bit time shows as corrupt data
    initial forever begin
        @(negedge line);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            got[i] = line;
        end
        repeat (BIT) @(posedge clk);
        if (line === 1'b1) got_cnt++;
    end
endmodule
`default_nettype wire

// ===== tb/asu_uart_test.sv
/*
 Testbench for the serial channel: Wishbone register tasks and frame traffic with the remote partner.
 Assumes divider 0 with the f1 source, giving 16 clocks per bit.
*/
`timescale 1ns/1ps
`default_nettype none
module asu_uart_test;
    import asu_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, line, rx_pin, so, soe, hs_o, hs_oe, txi, rxi;
    logic cts_b = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [5:0] adr = 6'h00;
    logic [31:0] dat = 32'h0, rdat, q, seen;
    logic [7:0] got;
    logic ack;
    int error_cnt = 0, total_checks = 0, got_cnt, n;
    int tx_irq_cnt = 0, rx_irq_cnt = 0;
    assign line = soe ? so : 1'b1;
    initial forever #2.5 clk = ~clk;
    asu_uart #(.CHANNEL(2)) dut (.clk(clk), .rst_b(rst_b), .wb_dat_i(dat), .wb_adr_i(adr), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serial_in_pin(rx_pin), .serial_out_pin(so), .serial_out_oe(soe), .transfer_clock_pin(1'b0),
        .handshake_pin_i(cts_b), .handshake_pin_o(hs_o), .handshake_pin_oe(hs_oe),
        .peer_handshake_pin(1'b1), .tx_irq(txi), .rx_irq(rxi)); // Peer pin only matters on channel 0
    asu_remote #(.BIT(16)) rem (.clk(clk), .line(line), .tx_line(rx_pin), .got(got), .got_cnt(got_cnt));
    // Interrupt pulses last one cycle, so they are counted rather than polled
    always @(posedge clk) begin
        if (txi === 1'b1) tx_irq_cnt++;
        if (rxi === 1'b1) rx_irq_cnt++;
    end
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 100);
        if (ack !== 1'b1) begin
            error_cnt++;
            $display("ERROR bus ack expected 1 seen %b", ack);
        end
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
        total_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic wait_rx(input int target);
        for (int k = 0; k < 3000 && got_cnt < target; k++) @(posedge clk);
        chk("frame count", target, got_cnt);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(0, ADDR_SERIAL_MODE, 0); chk("mode reset", {24'h0, RST_MODE}, q);
        xfer(0, ADDR_SERIAL_CONTROL_0, 0); chk("handshake off", 32'h10, q & 32'h10);
        chk("idle line", 1, line);
        xfer(1, ADDR_SERIAL_MODE, {29'h0, LEN_8});
        sel <= 4'h0;
        xfer(1, ADDR_SERIAL_MODE, {29'h0, LEN_9});
        sel <= 4'hF;
        xfer(0, ADDR_SERIAL_MODE, 0); chk("masked write ignored", {29'h0, LEN_8}, q);
        xfer(1, ADDR_BAUD_DIVIDER, 0);
        xfer(1, ADDR_SERIAL_CONTROL_0, 32'h10);
        xfer(1, ADDR_SERIAL_CONTROL_1, 32'h4);
        xfer(1, ADDR_TX_BUFFER, 32'h55);
        repeat (300) @(posedge clk);
        chk("no frame while disabled", 0, got_cnt);
        chk("receive only line", 1, line);
        $display("test disabled transmit done");
        xfer(1, ADDR_SERIAL_CONTROL_1, 32'h5);
        repeat (40) @(posedge clk);
        xfer(0, ADDR_SERIAL_CONTROL_0, 0); chk("shifter busy", 0, q & 32'h8);
        wait_rx(1); chk("lsb first byte", 8'h55, got);
        repeat (40) @(posedge clk);
        xfer(0, ADDR_SERIAL_CONTROL_0, 0); chk("shifter empty", 32'h8, q & 32'h8);
        xfer(0, ADDR_SERIAL_CONTROL_1, 0); chk("buffer empty", 32'h2, q & 32'h2);
        $display("test transmit done");
        xfer(1, ADDR_SERIAL_CONTROL_0, 32'h90);
        xfer(1, ADDR_TX_BUFFER, 32'h01);
        wait_rx(2); chk("msb first byte", 8'h80, got);
        chk("irq at load", 2, tx_irq_cnt);
        $display("test bit order done");
        repeat (40) @(posedge clk);
        cts_b <= 1'b1;
        xfer(1, ADDR_SERIAL_CONTROL_0, 32'h00);
        xfer(1, ADDR_SERIAL_CONTROL_1, 32'h15);
        xfer(1, ADDR_TX_BUFFER, 32'hA5);
        repeat (300) @(posedge clk);
        chk("held by clear to send", 2, got_cnt);
        cts_b <= 1'b0;
        wait_rx(3); chk("sent after clear", 8'hA5, got);
        chk("no irq before completion", 2, tx_irq_cnt);
        repeat (20) @(posedge clk);
        chk("irq at completion", 3, tx_irq_cnt);
        $display("test clear to send done");
        xfer(1, ADDR_SERIAL_CONTROL_0, 32'h10);
        rem.send(8'h3C);
        for (n = 0; n < 400 && rx_irq_cnt < 1; n++) @(posedge clk);
        chk("rx irq count", 1, rx_irq_cnt);
        xfer(0, ADDR_SERIAL_CONTROL_1, 0); chk("rx complete", 32'h8, q & 32'h8);
        xfer(0, ADDR_RX_BUFFER, 0); chk("rx data and flags", 32'h3C, q & 32'hF1FF);
        $display("test receive done");
        xfer(1, ADDR_SERIAL_CONTROL_0, 32'h04);
        repeat (2) @(posedge clk);
        chk("rts enable", 1, hs_oe);
        chk("rts ready", 0, hs_o);
        rem.send(8'h11);
        repeat (2) @(posedge clk);
        chk("rts busy", 1, hs_o);
        $display("test request to send done");
        xfer(0, 6'h2C, 0); chk("unmapped read", 0, q);
        $display("test unmapped done");
        end_of_test();
    end
endmodule
`default_nettype wire
